// file: asu_chan.sv
// one channel: transmit shifter and oversampling receiver
`timescale 1ns/1ps
module asu_chan
  import asu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic baudTick,
  input wire asu_frame_t frame,
  input wire logic txEn,
  input wire logic ctsOk,
  input wire logic txLoad,
  input wire logic [8:0] txData,
  input wire logic rxEn,
  input wire logic rxIn,
  input wire logic rxRead,
  output logic txLine,
  output logic txIdle,
  output logic txFull,
  output logic [8:0] rxData,
  output logic rxFull,
  output logic overrun,
  output logic frameErr,
  output logic parityErr
);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
    asu_rx_t;
  logic [3:0] txDiv_r, txLeft_r, rxDiv_r, rxIdx_r;
  logic [12:0] txSh_r;
  logic [8:0] txBuf_r, rxSh_r;
  logic txFull_r, rxPar_r, stopMore_r, stopBad_r;
  logic txBit, startTx, rxSample, rxDone, rxBad, rxPe;
  asu_rx_t rxSt_r;

  // start, data, parity, stop bits, first bit in position 0
  function automatic logic [16:0] txFrame(input logic [8:0] d,
                                          input asu_frame_t f);
    logic [12:0] v;
    logic [3:0] n;
    v = '1;
    v[0] = 1'b0;
    n = 4'h1;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < f.nBits) begin
        v[n] = d[i];
        n = n + 4'h1;
      end
    end
    if (f.parEn) begin
      v[n] = (^d) ^ f.parOdd;
      n = n + 4'h1;
    end
    n = n + (f.stop2 ? 4'h2 : 4'h1);
    return {n, v};
  endfunction

  assign txBit = baudTick && txDiv_r == SAMPLE_LAST;
  assign startTx = txBit && txLeft_r == 4'h0 && txFull_r && txEn && ctsOk;
  assign txLine = txSh_r[0];
  assign txIdle = txLeft_r == 4'h0;
  assign txFull = txFull_r;

  always_ff @(posedge clk_sys) begin
    if (rst || !frame.async) begin
      txDiv_r <= 4'h0;
    end else if (baudTick) begin
      txDiv_r <= txDiv_r + 4'h1;
    end
  end

  // leaving async mode empties the buffer and aborts the frame
  always_ff @(posedge clk_sys) begin
    if (rst || !frame.async) begin
      txFull_r <= 1'b0;
      txBuf_r <= 9'h000;
    end else if (txLoad) begin
      txFull_r <= 1'b1;
      txBuf_r <= txData & asuMask(frame.nBits);
    end else if (startTx) begin
      txFull_r <= 1'b0;
    end
  end

  // line rests high until the first frame starts
  always_ff @(posedge clk_sys) begin
    if (rst || !frame.async) begin
      txSh_r <= '1;
      txLeft_r <= 4'h0;
    end else if (startTx) begin
      {txLeft_r, txSh_r} <= txFrame(asuOrder(txBuf_r, frame), frame);
    end else if (txBit && txLeft_r != 4'h0) begin
      txSh_r <= {1'b1, txSh_r[12:1]};
      txLeft_r <= txLeft_r - 4'h1;
    end
  end

  assign rxSample = baudTick && rxDiv_r == SAMPLE_LAST;
  assign rxDone = rxSample && rxSt_r == RX_STOP && !stopMore_r;
  assign rxBad = stopBad_r || !rxIn;
  assign rxPe = frame.parEn &&
    (((^(rxSh_r & asuMask(frame.nBits))) ^ rxPar_r) != frame.parOdd);

  // dropping reception enable clears buffer state and flags
  always_ff @(posedge clk_sys) begin
    if (rst || !rxEn || !frame.async) begin
      rxSt_r <= RX_IDLE;
      rxDiv_r <= 4'h0;
      rxIdx_r <= 4'h0;
      rxSh_r <= 9'h000;
      rxPar_r <= 1'b0;
      stopMore_r <= 1'b0;
      stopBad_r <= 1'b0;
    end else if (baudTick) begin
      rxDiv_r <= rxDiv_r + 4'h1;
      unique case (rxSt_r)
        RX_IDLE: begin
          rxDiv_r <= 4'h0;
          if (!rxIn) rxSt_r <= RX_START;
        end
        RX_START: begin
          if (rxDiv_r == SAMPLE_MID) begin
            rxDiv_r <= 4'h0;
            rxIdx_r <= 4'h0;
            stopBad_r <= 1'b0;
            rxSt_r <= rxIn ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rxSample) begin
            rxSh_r[rxIdx_r] <= rxIn;
            rxIdx_r <= rxIdx_r + 4'h1;
            stopMore_r <= frame.stop2;
            if (rxIdx_r == frame.nBits - 4'h1) begin
              rxSt_r <= frame.parEn ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rxSample) begin
            rxPar_r <= rxIn;
            rxSt_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rxSample) begin
            stopBad_r <= rxBad;
            stopMore_r <= 1'b0;
            if (!stopMore_r) rxSt_r <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // a completed frame outranks the read that clears the full flag
  always_ff @(posedge clk_sys) begin
    if (rst || !rxEn || !frame.async) begin
      rxFull <= 1'b0;
      rxData <= 9'h000;
      overrun <= 1'b0;
      frameErr <= 1'b0;
      parityErr <= 1'b0;
    end else if (rxDone && rxFull && !rxRead) begin
      overrun <= 1'b1;
    end else if (rxDone) begin
      rxFull <= 1'b1;
      rxData <= asuOrder(rxSh_r & asuMask(frame.nBits), frame);
      frameErr <= rxBad;
      parityErr <= rxPe;
    end else if (rxRead) begin
      rxFull <= 1'b0;
    end
  end
endmodule

// file: asu_pkg.sv
// constants, carriers and helpers shared by the serial unit
package asu_pkg;
  localparam int NUM_CH = 3;
  localparam int NUM_GROUPS = 4;
  localparam int INV_CH = 2;
  localparam int REMAP_CH = 1;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] SAMPLE_MID = 4'h7;
  localparam logic [3:0] SAMPLE_LAST = 4'(OVERSAMPLE - 1);
  // register map, channel i at i * 32
  localparam logic [4:0] OFF_MODE = 5'h00;
  localparam logic [4:0] OFF_CTRL = 5'h04;
  localparam logic [4:0] OFF_BAUD = 5'h08;
  localparam logic [4:0] OFF_TXBUF = 5'h0C;
  localparam logic [4:0] OFF_RXBUF = 5'h10;
  localparam logic [1:0] GLOBAL_SLOT = 2'h3;
  localparam logic [4:0] OFF_GLOBAL = 5'h00;
  // mode register fields
  localparam logic [2:0] MODE_DISABLED = 3'h0;
  localparam logic [2:0] MODE_ASYNC7 = 3'h4;
  localparam logic [2:0] MODE_ASYNC8 = 3'h5;
  localparam logic [2:0] MODE_ASYNC9 = 3'h6;
  localparam int MODE_CKSRC = 3;
  localparam int MODE_STOP2 = 4;
  localparam int MODE_PAREN = 5;
  localparam int MODE_PARODD = 6;
  localparam int MODE_POLINV = 7;
  localparam logic [7:0] MODE_WMASK = 8'h7F;
  localparam logic [7:0] MODE_WMASK_INV = 8'hFF;
  // control register fields
  localparam int CTRL_SRC = 0;
  localparam int CTRL_HSSEL = 2;
  localparam int CTRL_TXEPT = 3;
  localparam int CTRL_HSDIS = 4;
  localparam int CTRL_NCH = 5;
  localparam int CTRL_ORDER = 7;
  localparam int CTRL_TE = 8;
  localparam int CTRL_TI = 9;
  localparam int CTRL_RE = 10;
  localparam int CTRL_RI = 11;
  localparam int CTRL_DINV = 12;
  localparam logic [15:0] CTRL_WMASK = 16'h05B7;
  localparam logic [15:0] CTRL_WMASK_INV = 16'h15B7;
  localparam logic [15:0] CTRL_RST = 16'h0010;
  // receive buffer flags
  localparam int RX_OER = 12;
  localparam int RX_FER = 13;
  localparam int RX_PER = 14;
  localparam int RX_SUM = 15;
  // global register fields
  localparam int GL_SEPCTS = 0;
  localparam int GL_CKOUT = 1;
  localparam int GL_REMAP = 2;
  localparam logic [2:0] GL_WMASK = 3'h7;
  // baud count sources: f1, f8, f32, f2
  localparam logic [1:0] SRC_F1 = 2'h0;
  localparam logic [1:0] SRC_F8 = 2'h1;
  localparam logic [1:0] SRC_F32 = 2'h2;
  localparam logic [1:0] SRC_F2 = 2'h3;

  typedef struct packed {
    logic async;
    logic [3:0] nBits;
    logic stop2;
    logic parEn;
    logic parOdd;
    logic msbFirst;
  } asu_frame_t;

  typedef struct packed {
    logic tx;
    logic txOe;
    logic clk;
    logic clkOe;
    logic hs;
    logic hsOe;
    logic rxFree;
    logic clkFree;
    logic hsFree;
  } asu_pin_out_t;

  typedef struct packed {
    logic rx;
    logic clk;
    logic hs;
  } asu_pin_in_t;

  localparam asu_pin_out_t PINS_RELEASED = 9'h007;

  function automatic logic [3:0] asuDataBits(input logic [2:0] mode);
    unique case (mode)
      MODE_ASYNC7: return 4'h7;
      MODE_ASYNC8: return 4'h8;
      MODE_ASYNC9: return 4'h9;
      default: return 4'h0;
    endcase
  endfunction

  function automatic logic [8:0] asuMask(input logic [3:0] nBits);
    return 9'(({9'h000, 1'b1} << nBits) - 10'h001);
  endfunction

  function automatic logic [8:0] asuOrder(input logic [8:0] d,
                                          input asu_frame_t f);
    logic [8:0] r;
    r = d;
    if (f.msbFirst && f.nBits == 4'h8) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = d[7 - i];
      end
    end
    return r;
  endfunction
endpackage

// file: asu_remote.sv
// remote transceiver model: decodes each frame and echoes it back
`timescale 1ns/1ps
module asu_remote (
  input wire logic clk_sys,
  input wire logic line,
  input wire logic [3:0] nBits,
  input wire logic polInv,
  input wire logic badStop,
  input wire logic [7:0] bitCyc,
  output logic rxOut,
  output logic ctsN,
  output logic [8:0] got,
  output logic [7:0] frames
);
  logic lvl = 1'b1;
  logic [8:0] w;
  assign rxOut = lvl ^ polInv;
  assign ctsN = 1'b0;
  initial begin
    frames = 8'h00;
    got = 9'h000;
    forever begin
      @(negedge clk_sys iff !(line ^ polInv));
      w = 9'h000;
      repeat (bitCyc / 2) @(negedge clk_sys);
      for (int i = 0; i < nBits; i++) begin
        repeat (bitCyc) @(negedge clk_sys);
        w[i] = line ^ polInv;
      end
      repeat (bitCyc) @(negedge clk_sys);
      if (line ^ polInv) begin
        got = w;
        frames = frames + 8'h01;
      end
      @(posedge clk_sys);
      // a bad stop is short so it cannot pass for a new start bit
      // signed bound: an unsigned count would skip the whole frame
      for (int i = -1; i <= int'(nBits); i++) begin
        lvl <= (i < 0) ? 1'b0 : (i == nBits) ? !badStop : w[i];
        repeat ((i == nBits && badStop) ? bitCyc / 2 + 4 : bitCyc)
          @(posedge clk_sys);
      end
      lvl <= 1'b1;
    end
  end
endmodule

// file: asu_top.sv
// three-channel asynchronous serial unit with an AHB-Lite register slave
//
// Behaviour
// - frame length selects used buffer bits
// - transmit line high before first transfer
// - open-drain transmit line floats while idle
// - receive-only channel keeps transmit line high
// - transmit-only channel frees receive pin
// - clock source bit picks port or clock
// - handshake pin: port, CTS or RTS
// - second channel pin carries first channel CTS
// - remap moves second channel pins to alternate
// - bit rate is baud output over 16
// - reception enable off-on resets receive buffer
// - mode off, async, enable resets transmit
// - bit order applies to 8-bit frames only
// - third channel inverts written transmit data
// - third channel inverts read receive data
// - third channel inverts line polarity fully
// - split handshake disables second channel handshake
// - mode codes 100/101/110 pick 7/8/9 bits
// - error sum flags any receive error
// - missing stop bit flags framing error
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module asu_top
  import asu_pkg::*;
#(
  parameter int BAUD_WIDTH = 8
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire asu_pin_in_t [NUM_GROUPS-1:0] pinIn,
  output asu_pin_out_t [NUM_GROUPS-1:0] pinOut
);
  logic [7:0] modeReg_r [NUM_CH];
  logic [15:0] ctrlReg_r [NUM_CH];
  logic [BAUD_WIDTH-1:0] baudReg_r [NUM_CH];
  logic [BAUD_WIDTH-1:0] baudCnt_r [NUM_CH];
  logic [2:0] globalReg_r;
  logic [4:0] preCnt_r;
  logic [NUM_CH-1:0] clkPrev_r;
  logic wrPend_r;
  logic [7:0] wrAddr_r;
  logic [31:0] hrdata_r;

  asu_frame_t frame [NUM_CH];
  asu_pin_out_t chOut [NUM_CH];
  asu_pin_in_t chIn [NUM_CH];
  logic [NUM_CH-1:0] baudTick, srcTick, txLoad, rxRead, ctsOk;
  logic [NUM_CH-1:0] ctsEn, rtsEn, polInv, dataInv;
  logic [NUM_CH-1:0] txLine, txIdle, txFull, rxFull;
  logic [NUM_CH-1:0] overrun, frameErr, parityErr;
  logic [8:0] rxData [NUM_CH];
  logic [8:0] txWord [NUM_CH];
  logic [3:0] preTick;
  logic addrOk, rdReq, splitActive;
  logic [31:0] rdVal;

  function automatic logic [1:0] slotOf(input logic [7:0] a);
    return a[6:5];
  endfunction

  function automatic logic [4:0] regOf(input logic [7:0] a);
    return a[4:0];
  endfunction

  // ---------------- bus slave ----------------
  // a read right behind a write waits one cycle so it sees the new value
  assign rdReq = hsel && htrans[1] && !hwrite;
  assign hreadyout = !(wrPend_r && rdReq);
  assign addrOk = hsel && htrans[1] && hready;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
    end else begin
      wrPend_r <= addrOk && hwrite;
      if (addrOk && hwrite) wrAddr_r <= haddr[7:0];
    end
  end

  always_comb begin
    rdVal = 32'h0000_0000;
    if (slotOf(haddr[7:0]) == GLOBAL_SLOT) begin
      if (regOf(haddr[7:0]) == OFF_GLOBAL) rdVal[2:0] = globalReg_r;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (slotOf(haddr[7:0]) == 2'(c)) begin
          unique case (regOf(haddr[7:0]))
            OFF_MODE: rdVal[7:0] = modeReg_r[c];
            OFF_CTRL: begin
              rdVal[15:0] = ctrlReg_r[c];
              rdVal[CTRL_TXEPT] = txIdle[c];
              rdVal[CTRL_TI] = !txFull[c];
              rdVal[CTRL_RI] = rxFull[c];
            end
            OFF_BAUD: rdVal[BAUD_WIDTH-1:0] = baudReg_r[c];
            OFF_RXBUF: begin
              rdVal[8:0] = dataInv[c] ?
                (~rxData[c] & asuMask(frame[c].nBits)) : rxData[c];
              rdVal[RX_OER] = overrun[c];
              rdVal[RX_FER] = frameErr[c];
              rdVal[RX_PER] = parityErr[c];
              rdVal[RX_SUM] = overrun[c] || frameErr[c] || parityErr[c];
            end
            default: rdVal = 32'h0000_0000;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hrdata_r <= 32'h0000_0000;
    end else if (addrOk && !hwrite) begin
      hrdata_r <= rdVal;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      globalReg_r <= 3'h0;
    end else if (wrPend_r && slotOf(wrAddr_r) == GLOBAL_SLOT &&
                 regOf(wrAddr_r) == OFF_GLOBAL) begin
      globalReg_r <= hwdata[2:0] & GL_WMASK;
    end
  end

  // ---------------- count source prescaler ----------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      preCnt_r <= 5'h00;
    end else begin
      preCnt_r <= preCnt_r + 5'h01;
    end
  end

  always_comb begin
    preTick = 4'h0;
    preTick[SRC_F1] = 1'b1;
    preTick[SRC_F8] = preCnt_r[2:0] == 3'h7;
    preTick[SRC_F32] = preCnt_r == 5'h1F;
    preTick[SRC_F2] = preCnt_r[0];
  end

  // ---------------- handshake sharing ----------------
  // the split path needs RTS on the first channel and no clock output
  assign splitActive = globalReg_r[GL_SEPCTS] && !globalReg_r[GL_CKOUT] &&
    rtsEn[0];

  // ---------------- per channel ----------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    localparam logic [7:0] MW = (c == INV_CH) ? MODE_WMASK_INV : MODE_WMASK;
    localparam logic [15:0] CW = (c == INV_CH) ? CTRL_WMASK_INV : CTRL_WMASK;
    logic wrHere;

    assign wrHere = wrPend_r && slotOf(wrAddr_r) == 2'(c);

    always_ff @(posedge clk_sys) begin
      if (rst) begin
        modeReg_r[c] <= 8'h00;
        ctrlReg_r[c] <= CTRL_RST;
        baudReg_r[c] <= '0;
      end else if (wrHere) begin
        if (regOf(wrAddr_r) == OFF_MODE) modeReg_r[c] <= hwdata[7:0] & MW;
        if (regOf(wrAddr_r) == OFF_CTRL) ctrlReg_r[c] <= hwdata[15:0] & CW;
        if (regOf(wrAddr_r) == OFF_BAUD) begin
          baudReg_r[c] <= hwdata[BAUD_WIDTH-1:0];
        end
      end
    end

    assign txLoad[c] = wrHere && regOf(wrAddr_r) == OFF_TXBUF;
    assign rxRead[c] = addrOk && !hwrite && slotOf(haddr[7:0]) == 2'(c) &&
      regOf(haddr[7:0]) == OFF_RXBUF;
    assign polInv[c] = modeReg_r[c][MODE_POLINV];
    assign dataInv[c] = ctrlReg_r[c][CTRL_DINV];
    assign txWord[c] = dataInv[c] ? ~hwdata[8:0] : hwdata[8:0];

    always_comb begin
      frame[c].nBits = asuDataBits(modeReg_r[c][2:0]);
      frame[c].async = frame[c].nBits != 4'h0;
      frame[c].stop2 = modeReg_r[c][MODE_STOP2];
      frame[c].parEn = modeReg_r[c][MODE_PAREN];
      frame[c].parOdd = modeReg_r[c][MODE_PARODD];
      frame[c].msbFirst = ctrlReg_r[c][CTRL_ORDER];
    end

    // external edges replace the prescaler when the pin is the clock
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        clkPrev_r[c] <= 1'b0;
      end else begin
        clkPrev_r[c] <= chIn[c].clk;
      end
    end

    assign srcTick[c] = modeReg_r[c][MODE_CKSRC] ?
      (chIn[c].clk && !clkPrev_r[c]) :
      preTick[ctrlReg_r[c][CTRL_SRC+:2]];

    always_ff @(posedge clk_sys) begin
      if (rst || !frame[c].async) begin
        baudCnt_r[c] <= '0;
      end else if (srcTick[c]) begin
        baudCnt_r[c] <= (baudCnt_r[c] == '0) ? baudReg_r[c] :
          baudCnt_r[c] - 1'b1;
      end
    end
    assign baudTick[c] = srcTick[c] && baudCnt_r[c] == '0;

    // second channel yields its handshake to the split path
    if (c == REMAP_CH) begin : g_shared
      assign ctsEn[c] = !ctrlReg_r[c][CTRL_HSDIS] &&
        !ctrlReg_r[c][CTRL_HSSEL] && !splitActive;
      assign rtsEn[c] = !ctrlReg_r[c][CTRL_HSDIS] &&
        ctrlReg_r[c][CTRL_HSSEL] && !splitActive;
    end else begin : g_own
      assign ctsEn[c] = !ctrlReg_r[c][CTRL_HSDIS] &&
        !ctrlReg_r[c][CTRL_HSSEL];
      assign rtsEn[c] = !ctrlReg_r[c][CTRL_HSDIS] &&
        ctrlReg_r[c][CTRL_HSSEL];
    end

    // clear-to-send is active low; split takes it from the shared pin
    if (c == 0) begin : g_cts0
      assign ctsOk[c] = splitActive ? !chIn[REMAP_CH].hs :
        (!ctsEn[c] || !chIn[c].hs);
    end else begin : g_ctsn
      assign ctsOk[c] = !ctsEn[c] || !chIn[c].hs;
    end

    asu_chan u_chan (
      .clk_sys(clk_sys),
      .rst(rst),
      .baudTick(baudTick[c]),
      .frame(frame[c]),
      .txEn(ctrlReg_r[c][CTRL_TE]),
      .ctsOk(ctsOk[c]),
      .txLoad(txLoad[c]),
      .txData(txWord[c]),
      .rxEn(ctrlReg_r[c][CTRL_RE]),
      .rxIn(chIn[c].rx ^ polInv[c]),
      .rxRead(rxRead[c]),
      .txLine(txLine[c]),
      .txIdle(txIdle[c]),
      .txFull(txFull[c]),
      .rxData(rxData[c]),
      .rxFull(rxFull[c]),
      .overrun(overrun[c]),
      .frameErr(frameErr[c]),
      .parityErr(parityErr[c])
    );

    always_comb begin
      chOut[c] = PINS_RELEASED;
      if (frame[c].async) begin
        if (ctrlReg_r[c][CTRL_NCH]) begin
          chOut[c].tx = 1'b0;
          chOut[c].txOe = !(txLine[c] ^ polInv[c]);
        end else begin
          chOut[c].tx = txLine[c] ^ polInv[c];
          chOut[c].txOe = 1'b1;
        end
        chOut[c].rxFree = !ctrlReg_r[c][CTRL_RE];
        chOut[c].clkFree = !modeReg_r[c][MODE_CKSRC];
        // request-to-send is low while the receiver can take a word
        chOut[c].hs = !(ctrlReg_r[c][CTRL_RE] && !rxFull[c]);
        chOut[c].hsOe = rtsEn[c];
        chOut[c].hsFree = !ctsEn[c] && !rtsEn[c] &&
          !(c == REMAP_CH && splitActive);
      end
    end
  end

  // ---------------- pin groups ----------------
  // group 3 is the alternate set of the second channel
  assign pinOut[0] = chOut[0];
  assign pinOut[2] = chOut[2];
  assign pinOut[1] = globalReg_r[GL_REMAP] ? PINS_RELEASED :
    chOut[REMAP_CH];
  assign pinOut[3] = globalReg_r[GL_REMAP] ? chOut[REMAP_CH] :
    PINS_RELEASED;
  assign chIn[0] = pinIn[0];
  assign chIn[2] = pinIn[2];
  assign chIn[REMAP_CH] = globalReg_r[GL_REMAP] ? pinIn[3] : pinIn[1];
endmodule

// file: asu_top_asserts.sv
// assertions on the bus and pin outputs of the serial unit
`timescale 1ns/1ps
module asu_top_asserts
  import asu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire asu_pin_out_t [NUM_GROUPS-1:0] pinOut
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  logic rdTaken;
  assign rdTaken = hsel && htrans[1] && !hwrite && hready;
  property p_reset_free;
    $fell(rst) |-> pinOut == {NUM_GROUPS{PINS_RELEASED}};
  endproperty
  a_reset_free: assert property (p_reset_free)
    else $error("pins not released after reset");
  // the fastest source still gives 16 clocks a bit, so a start lasts 16
  property p_start0;
    $fell(pinOut[0].tx) && pinOut[0].txOe |->
      (!pinOut[0].tx)[*8] ##1 (!pinOut[0].tx)[*8];
  endproperty
  a_start0: assert property (p_start0)
    else $error("short low bit on group 0");
  property p_start1;
    $fell(pinOut[1].tx) && pinOut[1].txOe |->
      (!pinOut[1].tx)[*8] ##1 (!pinOut[1].tx)[*8];
  endproperty
  a_start1: assert property (p_start1)
    else $error("short low bit on group 1");
  property p_hs_owner;
    pinOut[0].hsOe |-> !pinOut[0].hsFree;
  endproperty
  a_hs_owner: assert property (p_hs_owner)
    else $error("driven handshake pin left free");
  property p_clk_in;
    !pinOut[0].clkOe && !pinOut[1].clkOe && !pinOut[2].clkOe;
  endproperty
  a_clk_in: assert property (p_clk_in)
    else $error("clock pin driven");
  property p_remap;
    !(pinOut[1].txOe && pinOut[3].txOe);
  endproperty
  a_remap: assert property (p_remap)
    else $error("both second channel groups driven");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay)
    else $error("response not okay");
  property p_rdata_hold;
    !$past(rdTaken) |-> $stable(hrdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
endmodule

bind asu_top asu_top_asserts i_asu_top_asserts (.clk_sys(clk_sys),
  .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hresp(hresp), .hrdata(hrdata), .pinOut(pinOut));

// file: testbench.sv
// testbench: register access over the bus and framed traffic per channel
`timescale 1ns/1ps
module testbench;
  import asu_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata, junk, v;
  asu_pin_in_t [NUM_GROUPS-1:0] pinIn;
  asu_pin_out_t [NUM_GROUPS-1:0] pinOut;
  logic [1:0] grp = 2'h0;
  logic [3:0] nb = 4'h8;
  logic pol = 1'b0;
  logic badStop = 1'b0;
  logic ctsHold = 1'b0;
  logic lineNow, rxBack, ctsN;
  logic [8:0] got;
  logic [7:0] frames;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;

  asu_top i_asu_top (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pinIn(pinIn), .pinOut(pinOut));
  asu_remote i_asu_remote (.clk_sys(clk_sys), .line(lineNow),
    .nBits(nb), .polInv(pol), .badStop(badStop), .bitCyc(8'h20),
    .rxOut(rxBack), .ctsN(ctsN), .got(got), .frames(frames));

  // open-drain line floats high through the pull-up
  assign lineNow = pinOut[grp].txOe ? pinOut[grp].tx : 1'b1;
  always_comb begin
    for (int g = 0; g < NUM_GROUPS; g++) begin
      pinIn[g].rx = (g == grp) ? rxBack : 1'b1;
      pinIn[g].clk = 1'b0;
      pinIn[g].hs = ctsN | (g == 1 && ctsHold);
    end
  end

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      report_and_stop;
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic wr,
      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge clk_sys);
    while (!hreadyout) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_sys);
    while (!hreadyout) @(posedge clk_sys);
    rd = hrdata;
  endtask

  // group 3 is the second channel moved by the remap bit
  task automatic run_case(input logic [1:0] g, input logic [7:0] md,
      input logic [15:0] ct, input logic [8:0] d, input logic [8:0] w,
      input logic [8:0] r);
    logic [7:0] b;
    logic [7:0] f0;
    b = {1'b0, (g == 2'h3) ? 2'h1 : g, 5'h00};
    xfer(8'h60, 1'b1, {29'h0, g == 2'h3, 2'h0}, junk);
    nb <= 4'(md[2:0]) + 4'h3;
    xfer(b, 1'b1, 32'h0, junk);
    @(negedge clk_sys);
    chk(pinOut[g], PINS_RELEASED);
    xfer(b + 8'h08, 1'b1, 32'h1, junk);
    xfer(b, 1'b1, {24'h0, md}, junk);
    // switch line and polarity as the mode lands, else a false start
    grp <= g;
    pol <= md[MODE_POLINV];
    xfer(b + 8'h04, 1'b1, {16'h0, ct}, junk);
    @(negedge clk_sys);
    chk(lineNow, !md[MODE_POLINV]);
    chk(pinOut[g].txOe, !ct[CTRL_NCH]);
    chk({pinOut[g].hsOe, pinOut[g].hsFree}, {!ct[4] && ct[2], ct[4]});
    chk({pinOut[g].rxFree, pinOut[g].clkFree}, 2'h1);
    f0 = frames;
    xfer(b + 8'h0C, 1'b1, {23'h0, d}, junk);
    for (int k = 0; k < 900 && frames == f0; k++)
      @(posedge clk_sys);
    chk(got, w);
    v = 32'h0;
    for (int k = 0; k < 300 && !v[CTRL_RI]; k++)
      xfer(b + 8'h04, 1'b0, 32'h0, v);
    chk(pinOut[g].hs, 1'b1);
    xfer(b + 8'h10, 1'b0, 32'h0, v);
    chk(v[15:0], {badStop, 1'b0, badStop, 4'h0, r});
    chk(pinOut[g].hs, 1'b0);
    $display("test done: group %0d mode %h", g, md);
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    for (int g = 0; g < NUM_GROUPS; g++)
      chk(pinOut[g], PINS_RELEASED);
    xfer(8'h00, 1'b0, 32'h0, v);
    chk(v, 32'h0);
    xfer(8'h70, 1'b1, 32'hFFFFFFFF, junk);
    xfer(8'h70, 1'b0, 32'h0, v);
    chk(v, 32'h0);
    $display("test done: reset and unmapped");
    run_case(2'h0, 8'h04, 16'h0510, 9'h1A5, 9'h025, 9'h025);
    run_case(2'h0, 8'h05, 16'h0510, 9'h1A5, 9'h0A5, 9'h0A5);
    run_case(2'h0, 8'h06, 16'h0510, 9'h1A5, 9'h1A5, 9'h1A5);
    run_case(2'h0, 8'h05, 16'h0590, 9'h013, 9'h0C8, 9'h013);
    run_case(2'h0, 8'h04, 16'h0590, 9'h013, 9'h013, 9'h013);
    run_case(2'h0, 8'h05, 16'h0530, 9'h05A, 9'h05A, 9'h05A);
    run_case(2'h0, 8'h05, 16'h0504, 9'h0C3, 9'h0C3, 9'h0C3);
    run_case(2'h1, 8'h05, 16'h0500, 9'h081, 9'h081, 9'h081);
    run_case(2'h3, 8'h05, 16'h0510, 9'h07E, 9'h07E, 9'h07E);
    run_case(2'h2, 8'h05, 16'h1510, 9'h00F, 9'h0F0, 9'h00F);
    run_case(2'h2, 8'h85, 16'h0510, 9'h03C, 9'h03C, 9'h03C);
    badStop <= 1'b1;
    run_case(2'h0, 8'h05, 16'h0510, 9'h066, 9'h066, 9'h066);
    badStop <= 1'b0;
    xfer(8'h04, 1'b1, 32'h0110, junk);
    xfer(8'h04, 1'b1, 32'h0510, junk);
    xfer(8'h10, 1'b0, 32'h0, v);
    chk(v[15:12], 4'h0);
    $display("test done: receive recovery");
    xfer(8'h60, 1'b1, 32'h1, junk);
    xfer(8'h24, 1'b1, 32'h0, junk);
    xfer(8'h04, 1'b1, 32'h0504, junk);
    ctsHold <= 1'b1;
    xfer(8'h0C, 1'b1, 32'h55, junk);
    repeat (100) @(posedge clk_sys);
    xfer(8'h04, 1'b0, 32'h0, v);
    chk(v[CTRL_TI], 1'b0);
    ctsHold <= 1'b0;
    repeat (500) @(posedge clk_sys);
    chk(got, 9'h055);
    $display("test done: split handshake");
    report_and_stop;
  end
endmodule
